/* dphy_far_tx_model.sv */
// Behavioural far-end transmitter driving the receive pins
module dphy_far_tx_model
(
  output logic clk_lp,
  output logic data_lp,
  output logic data_hs,
  output logic hs_clk
);
  timeunit 1ns;
  timeprecision 1ns;

  // Lines idle at LP-11, HS clock standing still
  initial
  begin
    clk_lp = 1'b1;
    data_lp = 1'b1;
    data_hs = 1'b0;
    hs_clk = 1'b0;
  end

  // Clock lane into or out of HS, off the fabric edge
  task automatic clock_lane(input logic hs);
    #37 clk_lp = !hs;
  endtask

  // One burst: early edges inside settle, payload after it, then inverted trail
  task automatic burst(input int early, input int gap_ns, input int n, input logic [15:0] pat);
    int i;
    #37 data_lp = 1'b0;
    data_hs = 1'b1;
    for (i = 0; i < early; i++)
    begin
      #400 hs_clk = !hs_clk;
    end
    #(gap_ns - early * 400);
    for (i = 0; i < n; i++)
    begin
      data_hs = pat[i];
      #200 hs_clk = !hs_clk;
      #200;
    end
    data_hs = !data_hs;
    #100 data_lp = 1'b1;
  endtask
endmodule

/* dphy_lane_mode_sequencer.sv */
// Clock and data lane low-power / high-speed mode sequencer
//
// What this block does
// - Each lane alternates LP and HS mode with timed transitions on every switch.
// - HS entry steps the lane LP-11, LP-01, LP-00 in order.
// - HS exit drives the lane back to LP-11.
// - Clock keeps toggling for the post interval after data returns to LP.
// - HS clock runs at least 8 UI before data leaves LP.
// - Clock lane holds LP-00 200 ns (CLK_PREP_CYC + 1 cycles) before HS-0, not the 38 to 95 ns window.
// - Receiver ignores clock HS transitions during clock settle window.
// - Clock lane holds HS-0 at least 60 ns after last clock bit.
// - Clock prepare plus clock zero lasts at least 300 ns.
// - Data lane holds LP-00 200 ns (HS_PREP_CYC + 1 cycles) before HS-0, above the 97 ns prepare maximum.
// - Receiver ignores data HS transitions during data settle window.
// - Receiver responds to data transitions after settle window ends.
// - Data trail drives inverted state for the larger trail expression.
// - Every LP state lasts at least 50 ns.
// - Data prepare plus zero lasts at least the sync lead bound.
// - Clock and data settle timers configurable from 1 to 26 cycles (100 to 2600 ns).
module dphy_lane_mode_sequencer
  import dphy_seq_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              tx_req,
  input  wire logic              tx_last,
  input  wire logic              rx_clk_lp_in,
  input  wire logic              rx_data_lp_in,
  input  wire logic              rx_data_hs_in,
  input  wire logic              rx_hs_clk_in,
  input  settle_cfg_t            settle_cfg,
  output lane_drive_t            clk_lane,
  output lane_drive_t            data_lane,
  output logic                   clk_toggle_en,
  output logic                   tx_ready,
  output logic                   rx_data_valid,
  output logic                   rx_data_bit,
  output logic                   rx_clk_active
);

  ////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    tx_state_t        tx;
    logic [CNT_W-1:0] cnt;
    lane_drive_t      clk_lane;
    lane_drive_t      data_lane;
    logic             clk_toggle_en;
    logic             tx_ready;
    logic [1:0]       s_clk_lp;
    logic [1:0]       s_data_lp;
    logic [1:0]       s_data_hs;
    logic [1:0]       s_hs_clk;
    logic             hs_clk_d;
    logic             clk_lp_d;
    logic             data_lp_d;
    logic             rx_data_valid;
    logic             rx_data_bit;
    logic             rx_clk_active;
  } seq_t;

  seq_t st;
  seq_t next_st;

  logic             clk_start;
  logic             data_start;
  logic             clk_ignore;
  logic             clk_accept;
  logic             data_ignore;
  logic             data_accept;
  logic [CNT_W-1:0] clk_load;
  logic [CNT_W-1:0] data_load;

  // Clamp a requested settle count into the supported range
  function automatic logic [CNT_W-1:0] clamp_settle(input logic [CNT_W-1:0] v);
    if (v < SET_MIN_CYC)
      return SET_MIN_CYC;
    else if (v > SET_MAX_CYC)
      return SET_MAX_CYC;
    else
      return v;
  endfunction

  // Drive pattern for a lane in a low-power state
  function automatic lane_drive_t lp_drive(input logic [1:0] lp);
    lane_drive_t d;
    d       = '0;
    d.lp    = lp;
    return d;
  endfunction

  // Drive pattern for a lane in high-speed mode
  function automatic lane_drive_t hs_drive(input logic zero, input logic inv);
    lane_drive_t d;
    d         = '0;
    d.hs_en   = 1'b1;
    d.hs_zero = zero;
    d.hs_inv  = inv;
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Receive settle timers

  assign clk_load  = clamp_settle(settle_cfg.clk_settle);
  assign data_load = clamp_settle(settle_cfg.hs_settle);
  // Prepare begins when a lane falls into LP-00 from LP-01
  assign clk_start  = st.clk_lp_d & ~st.s_clk_lp[1];
  assign data_start = st.data_lp_d & ~st.s_data_lp[1];

  dphy_settle_timer u_clk_settle (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .start   (clk_start),
    .load    (clk_load),
    .ignore  (clk_ignore),
    .accept  (clk_accept)
  );

  dphy_settle_timer u_data_settle (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .start   (data_start),
    .load    (data_load),
    .ignore  (data_ignore),
    .accept  (data_accept)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    next_st = st;
    // Two-stage synchronisers for pin inputs
    next_st.s_clk_lp  = {st.s_clk_lp[0], rx_clk_lp_in};
    next_st.s_data_lp = {st.s_data_lp[0], rx_data_lp_in};
    next_st.s_data_hs = {st.s_data_hs[0], rx_data_hs_in};
    next_st.s_hs_clk  = {st.s_hs_clk[0], rx_hs_clk_in};
    next_st.hs_clk_d  = st.s_hs_clk[1];
    next_st.clk_lp_d  = st.s_clk_lp[1];
    next_st.data_lp_d = st.s_data_lp[1];

    // Receive: clock edges ignored in settle, data taken after it
    // Mask last window's accept in the start cycle
    next_st.rx_clk_active = ~clk_ignore & ~clk_start & clk_accept & ~st.s_clk_lp[1];
    next_st.rx_data_valid = 1'b0;
    if (data_accept && !data_ignore && !data_start && !st.s_data_lp[1]
        && st.s_hs_clk[1] != st.hs_clk_d)
    begin
      next_st.rx_data_valid = 1'b1;
      next_st.rx_data_bit   = st.s_data_hs[1];
    end

    // Interval down-counter
    if (st.cnt != '0)
      next_st.cnt = st.cnt - 8'h01;

    case (st.tx)
      TX_LP11:
      begin
        next_st.clk_lane      = lp_drive(LP11);
        next_st.data_lane     = lp_drive(LP11);
        next_st.clk_toggle_en = 1'b0;
        next_st.tx_ready      = 1'b0;
        if (tx_req && st.cnt == '0)
        begin
          next_st.tx       = TX_CLP01;
          next_st.clk_lane = lp_drive(LP01);
          next_st.cnt      = LPX_CYC;
        end
      end
      TX_CLP01:
        if (st.cnt == '0)
        begin
          next_st.tx       = TX_CLP00;
          next_st.clk_lane = lp_drive(LP00);
          next_st.cnt      = CLK_PREP_CYC;
        end
      TX_CLP00:
        if (st.cnt == '0)
        begin
          next_st.tx       = TX_CZERO;
          next_st.clk_lane = hs_drive(1'b1, 1'b0);
          next_st.cnt      = CLK_ZERO_CYC;
        end
      TX_CZERO:
        if (st.cnt == '0)
        begin
          next_st.tx            = TX_CPRE;
          next_st.clk_lane      = hs_drive(1'b0, 1'b0);
          next_st.clk_toggle_en = 1'b1;
          next_st.cnt           = CLK_PRE_CYC;
        end
      TX_CPRE:
        if (st.cnt == '0)
        begin
          next_st.tx        = TX_DLP01;
          next_st.data_lane = lp_drive(LP01);
          next_st.cnt       = LPX_CYC;
        end
      TX_DLP01:
        if (st.cnt == '0)
        begin
          next_st.tx        = TX_DLP00;
          next_st.data_lane = lp_drive(LP00);
          next_st.cnt       = HS_PREP_CYC;
        end
      TX_DLP00:
        if (st.cnt == '0)
        begin
          next_st.tx        = TX_DZERO;
          next_st.data_lane = hs_drive(1'b1, 1'b0);
          next_st.cnt       = HS_ZERO_CYC;
        end
      TX_DZERO:
        if (st.cnt == '0)
        begin
          next_st.tx        = TX_BURST;
          next_st.data_lane = hs_drive(1'b0, 1'b0);
          next_st.tx_ready  = 1'b1;
        end
      TX_BURST:
        if (tx_last)
        begin
          next_st.tx        = TX_DTRAIL;
          next_st.tx_ready  = 1'b0;
          next_st.data_lane = hs_drive(1'b0, 1'b1);
          next_st.cnt       = HS_TRAIL_CYC;
        end
      TX_DTRAIL:
        if (st.cnt == '0)
        begin
          next_st.tx        = TX_CPOST;
          next_st.data_lane = lp_drive(LP11);
          next_st.cnt       = CLK_POST_CYC;
        end
      TX_CPOST:
        if (st.cnt == '0)
        begin
          next_st.tx            = TX_CTRAIL;
          next_st.clk_toggle_en = 1'b0;
          next_st.clk_lane      = hs_drive(1'b1, 1'b0);
          next_st.cnt           = CLK_TRAIL_CYC;
        end
      TX_CTRAIL:
        if (st.cnt == '0)
        begin
          next_st.tx       = TX_LP11;
          next_st.clk_lane = lp_drive(LP11);
          next_st.cnt      = LPX_CYC;
        end
      default:
      begin
        next_st.tx  = TX_LP11;
        next_st.cnt = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st           <= '0;
      st.tx        <= TX_LP11;
      st.clk_lane  <= '{hs_en: 1'b0, hs_zero: 1'b0, hs_inv: 1'b0, lp: LP11};
      st.data_lane <= '{hs_en: 1'b0, hs_zero: 1'b0, hs_inv: 1'b0, lp: LP11};
      st.s_clk_lp  <= 2'h3;
      st.s_data_lp <= 2'h3;
      st.clk_lp_d  <= 1'b1;
      st.data_lp_d <= 1'b1;
    end
    else
      st <= next_st;
  end

  // Outputs straight from state flops
  assign clk_lane      = st.clk_lane;
  assign data_lane     = st.data_lane;
  assign clk_toggle_en = st.clk_toggle_en;
  assign tx_ready      = st.tx_ready;
  assign rx_data_valid = st.rx_data_valid;
  assign rx_data_bit   = st.rx_data_bit;
  assign rx_clk_active = st.rx_clk_active;

endmodule

/* dphy_seq_check_sva.sv */
// Port timing checker for the lane mode sequencer
module dphy_seq_check
  import dphy_seq_pkg::*;
(
  input wire logic   ref_clk,
  input wire logic   resetn,
  input wire logic   rx_clk_lp_in,
  input wire logic   rx_data_lp_in,
  input lane_drive_t clk_lane,
  input lane_drive_t data_lane,
  input wire logic   clk_toggle_en,
  input wire logic   rx_data_valid,
  input wire logic   rx_clk_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Entry order and low-power state lengths
  property p_clk_entry;
    clk_lane.lp == LP11 ##1 clk_lane.lp != LP11 |-> clk_lane.lp == LP01;
  endproperty
  a_clk_entry: assert property (p_clk_entry) else $error("clock lane left LP-11 not via LP-01");

  property p_lpx;
    $changed(clk_lane.lp) && !clk_lane.hs_en |=> $stable(clk_lane.lp);
  endproperty
  a_lpx: assert property (p_lpx) else $error("low-power state held one cycle only");

  property p_clk_prep;
    $rose(clk_lane.hs_en) |-> $past(clk_lane.lp) == LP00 && $past(clk_lane.lp, 2) == LP00
      && $past(clk_lane.lp, 3) == LP01 ##0 clk_lane.hs_zero [*4];
  endproperty
  a_clk_prep: assert property (p_clk_prep) else $error("clock prepare or zero length wrong");

  property p_data_prep;
    $rose(data_lane.hs_en) |-> $past(data_lane.lp) == LP00 && $past(data_lane.lp, 2) == LP00
      && $past(data_lane.lp, 3) == LP01 ##0 data_lane.hs_zero [*3];
  endproperty
  a_data_prep: assert property (p_data_prep) else $error("data prepare or zero length wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // Clock lead, post and trail around the data burst
  property p_clk_pre;
    $fell(data_lane.lp == LP11) |-> $past(clk_toggle_en) && $past(clk_toggle_en, 2);
  endproperty
  a_clk_pre: assert property (p_clk_pre) else $error("data left LP-11 without clock lead");

  property p_clk_post;
    $rose(data_lane.lp == LP11) |-> clk_toggle_en [*3];
  endproperty
  a_clk_post: assert property (p_clk_post) else $error("clock stopped before post interval");

  property p_clk_trail;
    $fell(clk_toggle_en) |-> (clk_lane.hs_en && clk_lane.hs_zero) [*2];
  endproperty
  a_clk_trail: assert property (p_clk_trail) else $error("clock trail too short");

  property p_data_trail;
    $rose(data_lane.hs_inv) |-> data_lane.hs_inv [*2] ##1 data_lane.lp == LP11;
  endproperty
  a_data_trail: assert property (p_data_trail) else $error("data trail or exit wrong");

  ////////////////////////////////////////////////////////////////////////////////
  // Receive settle windows
  property p_clk_settle;
    $fell(rx_clk_lp_in) |-> !rx_clk_active [*5];
  endproperty
  a_clk_settle: assert property (p_clk_settle) else $error("clock active inside settle window");

  property p_data_settle;
    $fell(rx_data_lp_in) |-> !rx_data_valid [*5];
  endproperty
  a_data_settle: assert property (p_data_settle) else $error("data taken inside settle window");

  // Main scenarios reached
  c_burst: cover property ($rose(clk_toggle_en));
  c_rx_bit: cover property (rx_data_valid);
  c_clk_active: cover property ($rose(rx_clk_active));
endmodule

bind dphy_lane_mode_sequencer dphy_seq_check u_dphy_seq_check (.*);

/* dphy_seq_pkg.sv */
// Shared constants and carrier types for the lane mode sequencer
package dphy_seq_pkg;

  // Fabric clock rate and high-speed bit period
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned UI_PS          = 2000;

  // Transmit intervals in ns, T_CLK_PRE_UI in UI (UI terms folded in with the UI period)
  localparam int unsigned T_LPX_NS       = 50;
  localparam int unsigned T_CLK_PREP_NS  = 38;
  localparam int unsigned T_CLK_PREP_MAX = 95;
  localparam int unsigned T_CLK_PZ_NS    = 300;
  localparam int unsigned T_CLK_TRAIL_NS = 60;
  localparam int unsigned T_CLK_PRE_UI   = 8;
  localparam int unsigned T_CLK_POST_NS  = 60 + (52 * UI_PS) / 1000;
  localparam int unsigned T_HS_PREP_NS   = 40 + (4 * UI_PS) / 1000;
  localparam int unsigned T_HS_PREP_MAX  = 85 + (6 * UI_PS) / 1000;
  localparam int unsigned T_HS_PZ_NS     = 145 + (10 * UI_PS) / 1000;
  localparam int unsigned T_HS_TRAIL_A   = (8 * UI_PS) / 1000;
  localparam int unsigned T_HS_TRAIL_B   = 60 + (4 * UI_PS) / 1000;
  localparam int unsigned T_HS_TRAIL_NS  = (T_HS_TRAIL_A > T_HS_TRAIL_B) ? T_HS_TRAIL_A : T_HS_TRAIL_B;

  // Settle range and defaults
  localparam int unsigned SETTLE_MIN_NS  = 40;
  localparam int unsigned SETTLE_MAX_NS  = 2590;
  localparam int unsigned T_CLK_SETTLE_NS = 95;
  localparam int unsigned T_HS_SETTLE_NS  = 145 + (10 * UI_PS) / 1000;

  // Cycle counts: least times round up, none below one
  function automatic int unsigned cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned CNT_W = 8;
  localparam logic [CNT_W-1:0] LPX_CYC       = CNT_W'(cyc_up(T_LPX_NS));
  localparam logic [CNT_W-1:0] CLK_PREP_CYC  = CNT_W'(cyc_up(T_CLK_PREP_NS));
  localparam logic [CNT_W-1:0] CLK_ZERO_CYC  = CNT_W'(cyc_up(T_CLK_PZ_NS - T_CLK_PREP_NS));
  localparam logic [CNT_W-1:0] CLK_PRE_CYC   = CNT_W'(cyc_up((T_CLK_PRE_UI * UI_PS) / 1000));
  localparam logic [CNT_W-1:0] CLK_POST_CYC  = CNT_W'(cyc_up(T_CLK_POST_NS));
  localparam logic [CNT_W-1:0] CLK_TRAIL_CYC = CNT_W'(cyc_up(T_CLK_TRAIL_NS));
  localparam logic [CNT_W-1:0] HS_PREP_CYC   = CNT_W'(cyc_up(T_HS_PREP_NS));
  localparam logic [CNT_W-1:0] HS_ZERO_CYC   = CNT_W'(cyc_up(T_HS_PZ_NS - T_HS_PREP_NS));
  localparam logic [CNT_W-1:0] HS_TRAIL_CYC  = CNT_W'(cyc_up(T_HS_TRAIL_NS));
  localparam logic [CNT_W-1:0] SET_MIN_CYC   = CNT_W'(cyc_up(SETTLE_MIN_NS));
  localparam logic [CNT_W-1:0] SET_MAX_CYC   = CNT_W'(cyc_up(SETTLE_MAX_NS));
  localparam logic [CNT_W-1:0] CLK_SET_CYC   = CNT_W'(cyc_up(T_CLK_SETTLE_NS));
  localparam logic [CNT_W-1:0] HS_SET_CYC    = CNT_W'(cyc_up(T_HS_SETTLE_NS));

  // Low-power line states {p,n}
  localparam logic [1:0] LP11 = 2'h3;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP00 = 2'h0;

  // Transmit sequencer states
  typedef enum logic [11:0] {
    TX_LP11   = 12'h001,
    TX_CLP01  = 12'h002,
    TX_CLP00  = 12'h004,
    TX_CZERO  = 12'h008,
    TX_CPRE   = 12'h010,
    TX_DLP01  = 12'h020,
    TX_DLP00  = 12'h040,
    TX_DZERO  = 12'h080,
    TX_BURST  = 12'h100,
    TX_DTRAIL = 12'h200,
    TX_CPOST  = 12'h400,
    TX_CTRAIL = 12'h800
  } tx_state_t;

  // Lane drive carrier
  typedef struct packed {
    logic       hs_en;
    logic       hs_zero;
    logic       hs_inv;
    logic [1:0] lp;
  } lane_drive_t;

  // Settle timer configuration carrier
  typedef struct packed {
    logic [CNT_W-1:0] clk_settle;
    logic [CNT_W-1:0] hs_settle;
  } settle_cfg_t;

endpackage

/* dphy_settle_timer.sv */
// Receive settle window timer for one lane
module dphy_settle_timer
  import dphy_seq_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  ignore,
  output logic                  accept
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             run;
    logic             done;
  } timer_t;

  timer_t st;
  timer_t next_st;

  // Down-counter from prepare start; accept once window elapses
  always_comb
  begin
    next_st = st;
    if (start)
    begin
      next_st.cnt  = load;
      next_st.run  = 1'b1;
      next_st.done = 1'b0;
    end
    else if (st.run)
    begin
      if (st.cnt <= 8'h01)
      begin
        next_st.run  = 1'b0;
        next_st.done = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt - 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign ignore = st.run;
  assign accept = st.done;

endmodule

/* test_dphy_lane_mode_sequencer.sv */
// Self-checking bench for the lane mode sequencer
module test_dphy_lane_mode_sequencer
  import dphy_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [7:0]  cfg;
    logic [7:0]  early;
    logic [7:0]  n;
    logic [15:0] pat;
  } row_t;

  logic        ref_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        tx_req = 1'b0;
  logic        tx_last = 1'b0;
  settle_cfg_t settle_cfg = 16'h0101;
  logic        far_clk_lp;
  logic        far_data_lp;
  logic        far_data_hs;
  logic        far_hs_clk;
  lane_drive_t clk_lane;
  lane_drive_t data_lane;
  logic        clk_toggle_en;
  logic        tx_ready;
  logic        rx_data_valid;
  logic        rx_data_bit;
  logic        rx_clk_active;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  logic        rx_q [$];
  logic [7:0]  run_exp [10];
  row_t        rows [5] = '{'{8'h01, 8'h00, 8'h06, 16'h002d}, '{8'h08, 8'h01, 8'h08, 16'h00a5},
                            '{8'h1a, 8'h05, 8'h10, 16'hc3e1}, '{8'hff, 8'h05, 8'h04, 16'h0009},
                            '{8'h00, 8'h00, 8'h03, 16'h0006}};

  dphy_lane_mode_sequencer u_dphy_lane_mode_sequencer (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .tx_req        (tx_req),
    .tx_last       (tx_last),
    .rx_clk_lp_in  (far_clk_lp),
    .rx_data_lp_in (far_data_lp),
    .rx_data_hs_in (far_data_hs),
    .rx_hs_clk_in  (far_hs_clk),
    .settle_cfg    (settle_cfg),
    .clk_lane      (clk_lane),
    .data_lane     (data_lane),
    .clk_toggle_en (clk_toggle_en),
    .tx_ready      (tx_ready),
    .rx_data_valid (rx_data_valid),
    .rx_data_bit   (rx_data_bit),
    .rx_clk_active (rx_clk_active)
  );

  dphy_far_tx_model u_dphy_far_tx_model (
    .clk_lp  (far_clk_lp),
    .data_lp (far_data_lp),
    .data_hs (far_data_hs),
    .hs_clk  (far_hs_clk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, received bit log and hang limit
  always #50 ref_clk = !ref_clk;

  always @(posedge ref_clk)
  begin
    if (rx_data_valid === 1'b1)
      rx_q.push_back(rx_data_bit);
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and lane state helpers
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check_idle();
    chk("clock lane", clk_lane, {3'h0, LP11});
    chk("data lane", data_lane, {3'h0, LP11});
    chk("clock toggle", clk_toggle_en, 8'h00);
    chk("ready", tx_ready, 8'h00);
  endtask

  function automatic logic cond(input int i);
    case (i)
      0: return clk_lane.lp == LP01;
      1: return clk_lane.lp == LP00 && !clk_lane.hs_en;
      2, 9: return clk_lane.hs_en && !clk_toggle_en;
      3, 8: return clk_toggle_en && data_lane.lp == LP11 && !data_lane.hs_en;
      4: return data_lane.lp == LP01;
      5: return data_lane.lp == LP00 && !data_lane.hs_en;
      6: return data_lane.hs_en && data_lane.hs_zero;
      default: return data_lane.hs_inv;
    endcase
  endfunction

  // One burst, each lane state but LP-11 and the burst itself timed in turn; keep leaves the request up
  task automatic tx_burst(input logic keep);
    int i;
    int n;
    @(posedge ref_clk);
    tx_req <= 1'b1;
    for (i = 0; i < 10; i++)
    begin
      if (i == 7)
      begin
        chk("ready in burst", tx_ready, 8'h01);
        @(posedge ref_clk);
        tx_last <= 1'b1;
        @(posedge ref_clk);
        tx_last <= 1'b0;
        tx_req <= keep;
      end
      n = 0;
      while (cond(i) !== 1'b1 && n < 50)
      begin
        @(negedge ref_clk);
        n++;
      end
      n = 0;
      while (cond(i) === 1'b1 && n < 50)
      begin
        @(negedge ref_clk);
        n++;
      end
      chk("state cycles", 8'(n), run_exp[i]);
    end
    chk("clock lane exit", clk_lane, {3'h0, LP11});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, receive rows, bursts, reset during clock lane HS-0 entry
  initial
  begin
    int r;
    int i;
    int eff;
    run_exp = '{LPX_CYC + 8'h01, CLK_PREP_CYC + 8'h01, CLK_ZERO_CYC + 8'h01, CLK_PRE_CYC + 8'h01,
                LPX_CYC + 8'h01, HS_PREP_CYC + 8'h01, HS_ZERO_CYC + 8'h01, HS_TRAIL_CYC + 8'h01,
                CLK_POST_CYC + 8'h01, CLK_TRAIL_CYC + 8'h01};
    repeat (20) @(posedge ref_clk);
    check_idle();
    resetn <= 1'b1;
    for (r = 0; r < 5; r++)
    begin
      eff = (int'(rows[r].cfg) < int'(SET_MIN_CYC)) ? int'(SET_MIN_CYC) : int'(rows[r].cfg);
      eff = (eff > int'(SET_MAX_CYC)) ? int'(SET_MAX_CYC) : eff;
      @(posedge ref_clk);
      settle_cfg <= {rows[r].cfg, rows[r].cfg};
      rx_q.delete();
      @(posedge ref_clk);
      u_dphy_far_tx_model.clock_lane(1'b1);
      repeat (eff) @(posedge ref_clk);
      chk("clock early", rx_clk_active, 8'h00);
      repeat (8) @(posedge ref_clk);
      chk("clock active", rx_clk_active, 8'h01);
      u_dphy_far_tx_model.burst(rows[r].early, (eff + 8) * 100, rows[r].n, rows[r].pat);
      repeat (4) @(posedge ref_clk);
      chk("bit count", 8'(rx_q.size()), rows[r].n);
      for (i = 0; i < rows[r].n && i < rx_q.size(); i++)
        chk("bit", rx_q[i], rows[r].pat[i]);
      u_dphy_far_tx_model.clock_lane(1'b0);
      repeat (5) @(posedge ref_clk);
      chk("clock idle", rx_clk_active, 8'h00);
    end
    tx_burst(1'b1);
    tx_burst(1'b0);
    repeat (6) @(negedge ref_clk);
    check_idle();
    @(posedge ref_clk);
    tx_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b0;
    tx_req <= 1'b0;
    @(negedge ref_clk);
    check_idle();
    @(posedge ref_clk);
    resetn <= 1'b1;
    tx_burst(1'b0);
    finish_test();
  end
endmodule
